/* sim/fdo_option_regs_props.sv */
// checker: bus timing and register behaviour of the drive option block
`default_nettype none
module fdo_option_regs_props
   import fdo_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hard_reset_in,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // core side
   input wire logic core_density,
   input wire logic drive_sel,
   input wire logic density_out,
   input wire logic [1:0] drive_kind_select,
   input wire logic [1:0] rate_map_select,
   input wire logic precomp_off,
   input wire logic [1:0] drive_a_kind,
   input wire logic [1:0] drive_b_kind
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take, ok, wr_q;
   logic [31:0] wa_q;
   logic [1:0] dens_q;
   logic [7:0] store_q;
   logic [2:0] up_q;
   assign take = hsel && hready && htrans[1];
   assign ok = up_q == 3'h7;
   // model checks wait until a reset has rippled through the outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_q <= 3'h0;
      end else begin
         up_q <= hard_reset_in ? 3'h0 : (ok ? up_q : up_q + 3'h1);
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 32'h0;
      end else if (hready) begin
         wr_q <= take && hwrite;
         wa_q <= haddr;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dens_q <= 2'h0;
         store_q <= 8'hFF;
      end else if (hard_reset_in) begin
         dens_q <= 2'h0;
         store_q <= 8'hFF;
      end else if (wr_q && hready && wa_q == 32'h3C4) begin
         dens_q <= hwdata[3:2];
      end else if (wr_q && hready && wa_q == 32'h3C8) begin
         store_q <= hwdata[7:0];
      end
   end
   sequence rd_s(a);
      take && !hwrite && haddr == a;
   endsequence
   sequence wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   property rd_then(a, c);
      @(posedge hclk) disable iff (!hresetn || !ok) rd_s(a) |-> ##2 c;
   endproperty
   property route_p(a, s);
      @(posedge hclk) disable iff (!hresetn || !ok)
      take && !hwrite && haddr == a && drive_sel == s ##1 drive_sel == s
      |-> ##1 hrdata[1:0] == drive_kind_select
      && hrdata[4:3] == rate_map_select && hrdata[6] == precomp_off;
   endproperty
   rd_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite |-> ##1 wait_s) else $error("read wait wrong");
   wr_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && hwrite |=> hreadyout && !hresp) else $error("write wait");
   spare_zero_a: assert property (rd_then(32'h3CC, hrdata == 32'h0))
      else $error("spare word not zero");
   resv_bits_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      take && !hwrite && (haddr == 32'h3D0 || haddr == 32'h3D4)
      |-> ##2 (hrdata & 32'hFFFF_FFA4) == 32'h0) else $error("fixed bits");
   store_read_a: assert property (rd_then(32'h3C8,
      hrdata == {24'h0, store_q} && hrdata[1:0] == drive_a_kind
      && hrdata[3:2] == drive_b_kind)) else $error("type store wrong");
   dens_map_a: assert property (@(posedge hclk)
      disable iff (!hresetn || !ok) 1'b1 |=> density_out ==
      ($past(dens_q) == 2'h3 ? 1'b0 : $past(dens_q) == 2'h2 ? 1'b1 :
      $past(core_density))) else $error("density wrong");
   drv0_route_a: assert property (
      route_p(32'h3D0, 1'b0)) else $error("drive 0 settings");
   drv1_route_a: assert property (route_p(32'h3D4, 1'b1))
      else $error("drive 1 settings");
endmodule
bind fdo_option_regs fdo_option_regs_props u_fdo_option_regs_props (
   .hclk, .hresetn, .hard_reset_in, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hready, .hwdata, .hreadyout, .hresp, .hrdata, .core_density, .drive_sel,
   .density_out, .drive_kind_select, .rate_map_select, .precomp_off,
   .drive_a_kind, .drive_b_kind);
`default_nettype wire

/* sim/fdo_option_regs_tb.sv */
// testbench: register and core side checks of the drive option block
`default_nettype none
`define CHK(n, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("ERROR %s exp %h got %h", n, e, g); \
   end \
end
module fdo_option_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hard_reset_in, hsel, hwrite, core_density, drive_sel;
   logic hreadyout, hresp, density_out, precomp_off;
   logic [1:0] htrans, drive_kind_select, rate_map_select, ka, kb;
   logic [31:0] haddr, hwdata, hrdata;
   int mismatches, comparisons, cyc;
   int m[8];
   int msk[8] = '{0, 'h0C, 'hFF, 0, 'h5B, 'h5B, 0, 0};
   fdo_option_regs u_fdo_option_regs (.hclk, .hresetn, .hard_reset_in, .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
      .hreadyout, .hresp, .hrdata, .core_density, .drive_sel, .density_out,
      .drive_kind_select, .rate_map_select, .precomp_off,
      .drive_a_kind(ka), .drive_b_kind(kb));
   task automatic close_out();
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // no fixed latency assumed: each phase waits for the slave's ready
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [7:0] v, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, v};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input int i, input logic [7:0] v);
      logic [31:0] r;
      xfer(1'b1, 32'h3C0 + 32'(i * 4), v, r);
      m[i] = v & msk[i];
   endtask
   // density the drive should see for the modelled select and core level
   function automatic logic dens_exp();
      int dn;
      dn = m[1] >> 2;
      return dn == 3 ? 1'b0 : (dn == 2 ? 1'b1 : core_density);
   endfunction
   task automatic rd_all();
      logic [31:0] r;
      logic [31:0] st;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, 32'h3C0 + 32'(i * 4), 8'h0, r);
         if (i != 6) begin
            `CHK("reg", 32'(m[i]), r)
         end else begin
            st = {29'h0, core_density, dens_exp(), drive_sel};
            `CHK("status", st, r)
         end
      end
   endtask
   task automatic core_chk();
      int s, dn;
      logic de;
      @(posedge hclk);
      drive_sel <= 1'($urandom);
      core_density <= 1'($urandom);
      repeat (2) @(posedge hclk);
      s = m[4 + int'(drive_sel)];
      dn = m[1] >> 2;
      de = dn == 3 ? 1'b0 : (dn == 2 ? 1'b1 : core_density);
      `CHK("kind", 2'(s), drive_kind_select)
      `CHK("rate", 2'(s >> 3), rate_map_select)
      `CHK("precomp", 1'(s >> 6), precomp_off)
      `CHK("density", de, density_out)
      `CHK("type a", 2'(m[2]), ka)
      `CHK("type b", 2'(m[2] >> 2), kb)
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      logic [31:0] r;
      hresetn = 1'b0;
      {hard_reset_in, hsel, hwrite, core_density, drive_sel} = 5'h00;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      m = '{0, 0, 'hFF, 0, 0, 0, 0, 0};
      void'($urandom(90));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd_all();
      repeat (30) begin
         wr($urandom_range(7), 8'($urandom));
         core_chk();
      end
      // every density code, with the other bits random
      for (int c = 0; c < 4; c++) begin
         wr(1, 8'(c << 2) | (8'($urandom) & 8'hF3));
         repeat (3) core_chk();
         rd_all();
      end
      // a high address bit makes the word unmapped
      xfer(1'b1, 32'h1000_03C4, 8'h0C, r);
      xfer(1'b0, 32'h1000_03C8, 8'h0, r);
      `CHK("unmapped", 32'h0, r)
      rd_all();
      @(posedge hclk);
      hard_reset_in <= 1'b1;
      repeat (6) @(posedge hclk);
      hard_reset_in <= 1'b0;
      repeat (8) @(posedge hclk);
      m = '{0, 0, 'hFF, 0, 0, 0, 0, 0};
      rd_all();
      core_chk();
      close_out();
   end
endmodule
`default_nettype wire

/* verilog/fdo_ahb_slave.sv */
// module: ahb-lite slave front end with one wait state on reads
`default_nettype none
module fdo_ahb_slave
   import fdo_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   // register side
   output fdo_wr_s wr,
   output logic [7:0] rd_idx,
   output logic rd_hit,
   input wire logic [7:0] rd_data
);
   logic ap_q;
   logic wr_q;
   logic hit_q;
   logic [7:0] idx_q;
   logic rdy_q;
   logic [31:0] rdata_q;
   logic accept;

   assign accept = hsel && hready && htrans[1];
   assign hreadyout = rdy_q;
   assign hrdata = rdata_q;
   assign rd_idx = idx_q;
   assign rd_hit = hit_q;
   // write commits at the end of the data phase, byte in lane 0
   assign wr.en = ap_q && wr_q && hit_q;
   assign wr.idx = idx_q;
   assign wr.data = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= 1'b0;
         wr_q <= 1'b0;
         hit_q <= 1'b0;
         idx_q <= 8'h00;
         rdy_q <= 1'b1;
      end else if (accept) begin
         ap_q <= 1'b1;
         wr_q <= hwrite;
         hit_q <= (haddr[31:10] == 22'h000000);
         idx_q <= haddr[9:2];
         // reads wait a cycle so a write just before is already stored
         rdy_q <= hwrite;
      end else begin
         ap_q <= 1'b0;
         rdy_q <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else if (ap_q && !wr_q && !rdy_q) begin
         rdata_q <= {24'h000000, hit_q ? rd_data : 8'h00};
      end
   end
endmodule
`default_nettype wire

/* verilog/fdo_drive_opts.sv */
// module: one per-drive option register
`default_nettype none
module fdo_drive_opts
   import fdo_pkg::*;
#(
   parameter logic [7:0] INDEX = 8'hF4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hard_rst,
   // register write
   input wire fdo_wr_s wr,
   // contents
   output logic [7:0] value,
   output fdo_drv_cfg_s cfg
);
   logic [7:0] reg_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reg_q <= RST_DRIVE;
      end else if (hard_rst) begin
         reg_q <= RST_DRIVE;
      end else if (wr.en && wr.idx == INDEX) begin
         reg_q <= wr.data & DRV_WMASK;
      end
   end

   assign value = reg_q;
   assign cfg.kind = reg_q[DRV_KIND_LSB +: 2];
   assign cfg.rate = reg_q[DRV_RATE_LSB +: 2];
   assign cfg.precomp_off = reg_q[DRV_PRECOMP_BIT];
endmodule
`default_nettype wire

/* verilog/fdo_option_regs.sv */
// module: floppy drive option register group, top level
//
// The AHB-Lite interface to the registers was left to the implementer.
`default_nettype none
module fdo_option_regs
   import fdo_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // hard reset pin, asynchronous, active high
   input wire logic hard_reset_in,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // controller core side
   input wire logic core_density,
   input wire logic drive_sel,
   output logic density_out,
   output logic [1:0] drive_kind_select,
   output logic [1:0] rate_map_select,
   output logic precomp_off,
   // stored drive types
   output logic [1:0] drive_a_kind,
   output logic [1:0] drive_b_kind
);
   fdo_wr_s wr;
   logic [7:0] rd_idx;
   logic rd_hit;
   logic [7:0] rd_data;
   logic hreadyout_w;
   logic [31:0] hrdata_w;

   // hard reset synchroniser state
   logic hr_s1_q;
   logic hr_s2_q;
   logic hr_s3_q;
   logic hard_rst_q;

   // register contents
   logic [1:0] dens_sel_q;
   logic [7:0] kind_store_q;
   logic [7:0] drv_value [NUM_DRIVES];
   fdo_drv_cfg_s drv_cfg [NUM_DRIVES];

   // output stage
   fdo_dens_e dens_mode;
   fdo_drv_cfg_s sel_cfg;
   logic density_q;
   logic [1:0] kind_q;
   logic [1:0] rate_q;
   logic precomp_q;
   logic [1:0] a_kind_q;
   logic [1:0] b_kind_q;
   logic hresp_q;
   logic [7:0] status;

   // bus front end
   fdo_ahb_slave u_slave (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout_w),
      .hrdata(hrdata_w),
      .wr(wr),
      .rd_idx(rd_idx),
      .rd_hit(rd_hit),
      .rd_data(rd_data)
   );

   // hsize is unused: only whole-word transfers are expected
   assign hreadyout = hreadyout_w;
   assign hrdata = hrdata_w;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_q <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
      end
   end
   assign hresp = hresp_q;

   // three-stage synchroniser on the hard reset pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hr_s1_q <= 1'b0;
         hr_s2_q <= 1'b0;
         hr_s3_q <= 1'b0;
      end else begin
         hr_s1_q <= hard_reset_in;
         hr_s2_q <= hr_s1_q;
         hr_s3_q <= hr_s2_q;
      end
   end

   // a level counts only once two stages agree, filtering a single glitch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hard_rst_q <= 1'b0;
      end else if (hr_s2_q == hr_s3_q) begin
         hard_rst_q <= hr_s2_q;
      end
   end

   // density select field of the option register; other bits not kept here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dens_sel_q <= RST_OPTION[OPT_DENS_LSB +: 2];
      end else if (hard_rst_q) begin
         dens_sel_q <= RST_OPTION[OPT_DENS_LSB +: 2];
      end else if (wr.en && wr.idx == IDX_OPTION) begin
         dens_sel_q <= wr.data[OPT_DENS_LSB +: 2];
      end
   end

   // drive type store: all eight bits are plain storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kind_store_q <= RST_KIND_STORE;
      end else if (hard_rst_q) begin
         kind_store_q <= RST_KIND_STORE;
      end else if (wr.en && wr.idx == IDX_KIND_STORE) begin
         kind_store_q <= wr.data;
      end
   end

   // one option register per drive
   genvar g;
   generate
      for (g = 0; g < NUM_DRIVES; g++) begin : g_drv
         fdo_drive_opts #(
            .INDEX(IDX_DRIVE0 + 8'(g))
         ) u_drv (
            .hclk(hclk),
            .hresetn(hresetn),
            .hard_rst(hard_rst_q),
            .wr(wr),
            .value(drv_value[g]),
            .cfg(drv_cfg[g])
         );
      end
   endgenerate

   // decode density select into a forcing mode
   always_comb begin
      case (dens_sel_q)
         DENS_CODE_HIGH: dens_mode = DENS_HIGH;
         DENS_CODE_LOW: dens_mode = DENS_LOW;
         default: dens_mode = DENS_PASS;
      endcase
   end

   // registered density line toward the drive, one cycle behind the core
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         density_q <= 1'b0;
      end else begin
         case (dens_mode)
            DENS_HIGH: density_q <= 1'b1;
            DENS_LOW: density_q <= 1'b0;
            DENS_PASS: density_q <= core_density;
            default: density_q <= core_density;
         endcase
      end
   end

   // settings of the selected drive go to the core
   assign sel_cfg = drive_sel ? drv_cfg[1] : drv_cfg[0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kind_q <= RST_DRIVE[DRV_KIND_LSB +: 2];
         rate_q <= RST_DRIVE[DRV_RATE_LSB +: 2];
         precomp_q <= RST_DRIVE[DRV_PRECOMP_BIT];
      end else begin
         kind_q <= sel_cfg.kind;
         rate_q <= sel_cfg.rate;
         precomp_q <= sel_cfg.precomp_off;
      end
   end

   // drive A and B types from the store; upper fields drive nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_kind_q <= RST_KIND_STORE[KIND_A_LSB +: 2];
         b_kind_q <= RST_KIND_STORE[KIND_B_LSB +: 2];
      end else begin
         a_kind_q <= kind_store_q[KIND_A_LSB +: 2];
         b_kind_q <= kind_store_q[KIND_B_LSB +: 2];
      end
   end

   assign density_out = density_q;
   assign drive_kind_select = kind_q;
   assign rate_map_select = rate_q;
   assign precomp_off = precomp_q;
   assign drive_a_kind = a_kind_q;
   assign drive_b_kind = b_kind_q;

   // read-only view of live state: bit0 drive, bit1 density, bit2 core
   assign status = {5'h00, core_density, density_q, drive_sel};

   // read mux; unmapped and reserved indices read zero
   always_comb begin
      rd_data = 8'h00;
      if (rd_hit) begin
         case (rd_idx)
            IDX_OPTION: rd_data = {4'h0, dens_sel_q, 2'h0};
            IDX_KIND_STORE: rd_data = kind_store_q;
            IDX_SPARE: rd_data = 8'h00;
            IDX_DRIVE0: rd_data = drv_value[0] & DRV_WMASK;
            IDX_DRIVE1: rd_data = drv_value[1] & DRV_WMASK;
            IDX_STATUS: rd_data = status;
            default: rd_data = 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

/* verilog/fdo_pkg.sv */
// package: constants, types and register map of the drive option block
`default_nettype none
package fdo_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_OPTION = 8'hF1;
   localparam logic [7:0] IDX_KIND_STORE = 8'hF2;
   localparam logic [7:0] IDX_SPARE = 8'hF3;
   localparam logic [7:0] IDX_DRIVE0 = 8'hF4;
   localparam logic [7:0] IDX_DRIVE1 = 8'hF5;
   localparam logic [7:0] IDX_STATUS = 8'hF6;
   localparam int NUM_DRIVES = 2;
   // reset values
   localparam logic [7:0] RST_OPTION = 8'h00;
   localparam logic [7:0] RST_KIND_STORE = 8'hFF;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   // field positions
   localparam int OPT_DENS_LSB = 2;
   localparam int KIND_A_LSB = 0;
   localparam int KIND_B_LSB = 2;
   localparam int DRV_KIND_LSB = 0;
   localparam int DRV_RATE_LSB = 3;
   localparam int DRV_PRECOMP_BIT = 6;
   // writable bits of each per-drive register: 6, 4:3, 1:0
   localparam logic [7:0] DRV_WMASK = 8'h5B;
   // density select codes
   localparam logic [1:0] DENS_CODE_HIGH = 2'h2;
   localparam logic [1:0] DENS_CODE_LOW = 2'h3;
   // cycles a read holds hreadyout low
   localparam int READ_WAIT_CYCLES = 1;

   typedef enum {DENS_PASS, DENS_HIGH, DENS_LOW} fdo_dens_e;

   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [7:0] data;
   } fdo_wr_s;

   typedef struct packed {
      logic [1:0] kind;
      logic [1:0] rate;
      logic precomp_off;
   } fdo_drv_cfg_s;
endpackage
`default_nettype wire
